// File: src/co3_pkg.sv
package co3_pkg;
   // Command code and power-on value
   localparam logic [7:0] CO3_CMD = 8'h32;
   localparam logic [15:0] CO3_RESET = 16'h0434;
   // Field positions
   localparam int unsigned B_HIZ = 15;
   localparam int unsigned B_RST_ALL = 14;
   localparam int unsigned B_REMEAS = 13;
   localparam int unsigned B_REV = 12;
   localparam int unsigned B_ICO = 11;
   localparam int unsigned B_DRV = 10;
   localparam int unsigned B_SLEW = 9;
   localparam int unsigned B_BIGCAP = 8;
   localparam int unsigned B_SW_OFF = 7;
   localparam int unsigned B_PVP = 6;
   localparam int unsigned B_PINSEL = 5;
   localparam int unsigned B_CLAMP_HI = 4;
   localparam int unsigned B_CLAMP_LO = 3;
   localparam int unsigned B_CMP = 2;
   localparam int unsigned B_SW_IDLE = 1;
   localparam int unsigned B_PMON = 0;
   // Inductor clamp codes and limits in amperes
   localparam logic [1:0] CLAMP_6A = 2'h0;
   localparam logic [1:0] CLAMP_10A = 2'h1;
   localparam logic [1:0] CLAMP_15A = 2'h2;
   localparam logic [1:0] CLAMP_OFF = 2'h3;
   localparam logic [3:0] AMPS_6 = 4'h6;
   localparam logic [3:0] AMPS_10 = 4'hA;
   localparam logic [3:0] AMPS_15 = 4'hF;
   // Soft slew: one step per 8 us at 25 ns clock
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned SLEW_STEP_NS = 8000;
   localparam int unsigned SLEW_STEP_CYC = (SLEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] SLEW_LAST = 9'(SLEW_STEP_CYC - 1);
   // Remeasure states
   typedef enum logic [0:0] {
      MEAS_IDLE = 1'b0,
      MEAS_BUSY = 1'b1
   } co3_meas_t;
endpackage : co3_pkg

// File: src/co3_link_if.sv
`timescale 1ns/100ps
interface co3_link_if;
   logic [7:0] target;
   logic soft_en;
   logic [7:0] applied;
   logic meas_start;
   logic meas_abort;
   logic meas_done;
   logic meas_busy;
   modport top (output target, soft_en, meas_start, meas_abort, meas_done, input applied, meas_busy);
   modport slew (input target, soft_en, output applied);
   modport meas (input meas_start, meas_abort, meas_done, output meas_busy);
endinterface : co3_link_if

// File: src/co3_slew.sv
`timescale 1ns/100ps
module co3_slew
   import co3_pkg::*;
(
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Setting and applied value
   co3_link_if.slew lnk
);
   logic [8:0] tick;
   logic step_due;

   assign step_due = (tick == SLEW_LAST);

   // Step interval counter
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         tick <= 9'h000;
      end else if (ce_i) begin
         if (!lnk.soft_en || lnk.applied == lnk.target || step_due) begin
            tick <= 9'h000;
         end else begin
            tick <= tick + 9'h001;
         end
      end
   end

   // Applied value: direct or one step per interval
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         lnk.applied <= 8'h00;
      end else if (ce_i) begin
         if (!lnk.soft_en) begin
            lnk.applied <= lnk.target;
         end else if (step_due && lnk.applied < lnk.target) begin
            lnk.applied <= lnk.applied + 8'h01;
         end else if (step_due && lnk.applied > lnk.target) begin
            lnk.applied <= lnk.applied - 8'h01;
         end
      end
   end

   chk_slew_one_lsb: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(lnk.soft_en) && $changed(lnk.applied) |->
         (lnk.applied == $past(lnk.applied) + 8'h01) || (lnk.applied == $past(lnk.applied) - 8'h01))
      else $error("soft slew moved by more than one step");
   chk_slew_interval: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(lnk.soft_en) && $changed(lnk.applied) |-> $past(tick) == SLEW_LAST)
      else $error("soft slew stepped before the interval elapsed");
endmodule : co3_slew

// File: src/co3_meas.sv
`timescale 1ns/100ps
module co3_meas
   import co3_pkg::*;
(
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Request and completion
   co3_link_if.meas lnk
);
   co3_meas_t state;

   // Busy until measurement done or aborted; a new request wins over completion
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state <= MEAS_IDLE;
      end else if (ce_i) begin
         unique case (state)
            MEAS_IDLE: begin
               if (lnk.meas_start) begin
                  state <= MEAS_BUSY;
               end
            end
            MEAS_BUSY: begin
               if (!lnk.meas_start && (lnk.meas_done || lnk.meas_abort)) begin
                  state <= MEAS_IDLE;
               end
            end
         endcase
      end
   end

   assign lnk.meas_busy = (state == MEAS_BUSY);

   sequence s_busy_done;
      lnk.meas_busy && ce_i && lnk.meas_done && !lnk.meas_start;
   endsequence
   chk_meas_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_busy_done |=> !lnk.meas_busy)
      else $error("remeasure bit did not clear after completion");
   chk_meas_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      lnk.meas_busy && !lnk.meas_done && !lnk.meas_abort |=> lnk.meas_busy)
      else $error("remeasure bit dropped before completion");
endmodule : co3_meas

// File: src/co3_option_reg.sv
`timescale 1ns/100ps
// Contract
// - Register answers command 32h and powers up holding 0434h.
// - Bit 15 enters high-impedance mode; regulator on above lockout, system on battery.
// - Writing bit 14 resets all registers but threshold, then bit reads zero.
// - Writing bit 13 stops converter for remeasure; bit clears when done.
// - Reverse supply only when bit 12 set and mode pin high.
// - Bit 11 enables input current optimizer; default off.
// - Bit 10 (default 1) drives battery switch pin; 0 leaves it floating.
// - Bit 9 slews minimum system voltage one step per 8 us.
// - Bit 8 enables large port capacitance compensation in reverse supply.
// - Bit 7 accepted only battery-only; forced zero in battery-only reverse supply.
// - Bit 6 enables port voltage protection variant; default off.
// - Bit 5 picks mode pin function: 1 reverse supply, 0 protection.
// - Bits 4:3 set clamp 6A, 10A, 15A default, or disabled.
// - Bit 2 enables independent comparator; default enabled.
// - Bit 1 turns battery switch off during high-impedance mode.
// - Bit 0 selects power monitor in reverse supply: difference or discharge only.
module co3_option_reg
   import co3_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Register access
   input wire logic [7:0] cmd_i,
   input wire logic wr_i,
   input wire logic [15:0] wdata_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic rd_valid_o,
   // Device status
   input wire logic external_mode_pin_i,
   input wire logic battery_only_i,
   input wire logic input_above_uvlo_i,
   input wire logic remeasure_done_i,
   input wire logic [7:0] minimum_system_voltage_i,
   // Control outputs
   output logic all_reg_reset_o,
   output logic remeasure_start_o,
   output logic converter_disable_o,
   output logic high_impedance_mode_o,
   output logic regulator_on_o,
   output logic system_from_battery_o,
   output logic reverse_supply_active_o,
   output logic active_protection_pin_en_o,
   output logic port_voltage_protection_o,
   output logic large_port_capacitance_comp_o,
   output logic input_current_optimizer_enable_o,
   output logic independent_comparator_enable_o,
   output logic clamp_enable_o,
   output logic [3:0] clamp_amps_o,
   output logic power_monitor_subtract_port_o,
   output logic [7:0] minimum_system_voltage_o,
   // Battery switch driver pin
   output logic battery_switch_driver_pin_o,
   output logic battery_switch_driver_pin_oe_o
);
   co3_link_if lnk ();

   logic [15:0] opt;
   logic hit_wr;
   logic hit_rd;
   logic do_reset;
   logic rev_now;
   logic sw_ok;
   logic sw_off;
   logic [15:0] view;
   logic [3:0] next_amps;

   // Access decode
   assign hit_wr = wr_i && (cmd_i == CO3_CMD);
   assign hit_rd = rd_i && (cmd_i == CO3_CMD);
   assign do_reset = hit_wr && wdata_i[B_RST_ALL];

   // Mode decode from stored fields, mode pin and battery-only status
   assign rev_now = opt[B_REV] && opt[B_PINSEL] && external_mode_pin_i;
   assign sw_ok = battery_only_i && !rev_now;
   assign sw_off = opt[B_SW_OFF] || (opt[B_HIZ] && opt[B_SW_IDLE]);

   // Readback view with live remeasure bit
   always_comb begin
      view = opt;
      view[B_RST_ALL] = 1'b0;
      view[B_REMEAS] = lnk.meas_busy;
   end

   // Clamp limit decode
   always_comb begin
      unique case (opt[B_CLAMP_HI:B_CLAMP_LO])
         CLAMP_6A: next_amps = AMPS_6;
         CLAMP_10A: next_amps = AMPS_10;
         CLAMP_15A: next_amps = AMPS_15;
         CLAMP_OFF: next_amps = 4'h0;
      endcase
   end

   // Option register storage
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         opt <= CO3_RESET;
      end else if (ce_i) begin
         if (do_reset) begin
            opt <= CO3_RESET;
         end else if (hit_wr) begin
            opt <= wdata_i;
            opt[B_RST_ALL] <= 1'b0;
            opt[B_REMEAS] <= 1'b0;
            opt[B_SW_OFF] <= wdata_i[B_SW_OFF] && sw_ok;
         end else if (battery_only_i && rev_now) begin
            opt[B_SW_OFF] <= 1'b0;
         end
      end
   end

   // Register read port
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rdata_o <= 16'h0000;
         rd_valid_o <= 1'b0;
      end else if (ce_i) begin
         rd_valid_o <= hit_rd;
         if (hit_rd) begin
            rdata_o <= view;
         end
      end
   end

   // Reset and remeasure strobes
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         all_reg_reset_o <= 1'b0;
         remeasure_start_o <= 1'b0;
      end else if (ce_i) begin
         all_reg_reset_o <= do_reset;
         remeasure_start_o <= hit_wr && !do_reset && wdata_i[B_REMEAS];
      end
   end

   // Links to the remeasure tracker and the slew stepper
   assign lnk.meas_start = hit_wr && !do_reset && wdata_i[B_REMEAS];
   assign lnk.meas_abort = do_reset;
   assign lnk.meas_done = remeasure_done_i;
   assign lnk.target = minimum_system_voltage_i;
   assign lnk.soft_en = opt[B_SLEW];

   co3_meas u_meas (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .lnk(lnk.meas)
   );

   co3_slew u_slew (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .lnk(lnk.slew)
   );

   // Converter and power path controls
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         converter_disable_o <= 1'b0;
         high_impedance_mode_o <= 1'b0;
         regulator_on_o <= 1'b0;
         system_from_battery_o <= 1'b0;
      end else if (ce_i) begin
         converter_disable_o <= opt[B_HIZ] || lnk.meas_busy;
         high_impedance_mode_o <= opt[B_HIZ];
         regulator_on_o <= input_above_uvlo_i;
         system_from_battery_o <= opt[B_HIZ];
      end
   end

   // Mode pin and feature enables
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         reverse_supply_active_o <= 1'b0;
         active_protection_pin_en_o <= 1'b0;
         port_voltage_protection_o <= 1'b0;
         large_port_capacitance_comp_o <= 1'b0;
         input_current_optimizer_enable_o <= 1'b0;
         independent_comparator_enable_o <= 1'b0;
         power_monitor_subtract_port_o <= 1'b0;
      end else if (ce_i) begin
         reverse_supply_active_o <= rev_now;
         active_protection_pin_en_o <= !opt[B_PINSEL] && external_mode_pin_i;
         port_voltage_protection_o <= opt[B_PVP];
         large_port_capacitance_comp_o <= opt[B_BIGCAP] && rev_now;
         input_current_optimizer_enable_o <= opt[B_ICO];
         independent_comparator_enable_o <= opt[B_CMP];
         power_monitor_subtract_port_o <= rev_now && !opt[B_PMON];
      end
   end

   // Clamp, slewed voltage and battery switch pin
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         clamp_enable_o <= 1'b0;
         clamp_amps_o <= 4'h0;
         minimum_system_voltage_o <= 8'h00;
         battery_switch_driver_pin_o <= 1'b0;
         battery_switch_driver_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         clamp_enable_o <= opt[B_CLAMP_HI:B_CLAMP_LO] != CLAMP_OFF;
         clamp_amps_o <= next_amps;
         minimum_system_voltage_o <= lnk.applied;
         battery_switch_driver_pin_o <= !sw_off;
         battery_switch_driver_pin_oe_o <= opt[B_DRV];
      end
   end

   sequence s_reset_write;
      ce_i && do_reset;
   endsequence
   sequence s_remeas_write;
      ce_i && lnk.meas_start;
   endsequence

   chk_por_value: assert property (@(posedge clk_i)
      !rst_b_i |=> opt == CO3_RESET)
      else $error("option register missed its power-on value");
   chk_reset_all: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_reset_write |=> all_reg_reset_o && opt == CO3_RESET && !view[B_RST_ALL])
      else $error("register reset did not restore defaults");
   chk_remeas_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_remeas_write ##1 ce_i |=> converter_disable_o && remeasure_start_o == 1'b0)
      else $error("converter not stopped for remeasure");
   chk_reverse_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i |=> reverse_supply_active_o == ($past(opt[B_REV]) && $past(opt[B_PINSEL])
         && $past(external_mode_pin_i)))
      else $error("reverse supply not gated by bit and pin");
   chk_sw_off_refused: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && hit_wr && !do_reset && !sw_ok |=> !opt[B_SW_OFF])
      else $error("switch force-off accepted outside battery-only");
   chk_sw_off_forced: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && battery_only_i && rev_now && !do_reset |=> !opt[B_SW_OFF])
      else $error("switch force-off kept during reverse supply");
   chk_pin_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rst_b_i && ce_i |=> battery_switch_driver_pin_oe_o == $past(opt[B_DRV]))
      else $error("driver pin enable does not follow bit 10");
   chk_clamp_map: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rst_b_i && ce_i && opt[B_CLAMP_HI:B_CLAMP_LO] == CLAMP_15A |=> clamp_enable_o && clamp_amps_o == AMPS_15)
      else $error("inductor clamp code decoded wrongly");
   chk_idle_switch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && opt[B_HIZ] && opt[B_SW_IDLE] |=> !battery_switch_driver_pin_o)
      else $error("battery switch left on in high-impedance mode");
   chk_read_live: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && hit_rd |=> rd_valid_o && rdata_o[B_REMEAS] == $past(lnk.meas_busy))
      else $error("readback does not show remeasure state");
   chk_pmon_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && rev_now && opt[B_PMON] |=> !power_monitor_subtract_port_o)
      else $error("power monitor selection ignored");
endmodule : co3_option_reg

// File: sim/co3_host_model.sv
`timescale 1ns/100ps
module co3_host_model
   import co3_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register access
   output logic [7:0] cmd_o,
   output logic wr_o,
   output logic [15:0] wdata_o,
   output logic rd_o,
   input wire logic [15:0] rdata_i,
   input wire logic rd_valid_i,
   // Threshold measurement
   input wire logic remeasure_start_i,
   output logic remeasure_done_o
);
   int meas_delay = 40;
   int meas_cnt;
   // Idle bus values at time zero
   initial begin
      cmd_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 16'hA5A5;
   end
   // One write: strobe held for exactly one taking edge
   task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data);
      @(posedge clk_i);
      cmd_o <= cmd;
      wdata_o <= data;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~data; // Stale data never lingers on the bus
   endtask : write_reg
   // One read: answer sampled in the cycle after the taking edge
   task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data, output logic valid);
      @(posedge clk_i);
      cmd_o <= cmd;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(negedge clk_i);
      valid = rd_valid_i;
      data = rdata_i;
   endtask : read_reg
   // Measurement unit: finishes a set number of cycles after each start
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         meas_cnt <= 0;
         remeasure_done_o <= 1'b0;
      end else begin
         remeasure_done_o <= 1'b0;
         if (remeasure_start_i === 1'b1) begin
            meas_cnt <= meas_delay;
         end else if (meas_cnt == 1) begin
            remeasure_done_o <= 1'b1;
            meas_cnt <= 0;
         end else if (meas_cnt > 1) begin
            meas_cnt <= meas_cnt - 1;
         end
      end
   end
endmodule : co3_host_model

// File: sim/charger_option_three_register_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) check(32'(got), 32'(exp))
module charger_option_three_register_tb_top;
   import co3_pkg::*;
   logic clk_i, rst_b_i, ce_i, b_wr, b_rd, b_rv, ext_pin, batt_only, uvlo_ok, m_done;
   logic [7:0] b_cmd, vmin_in, vmin_out;
   logic [15:0] b_wd, b_rdata, rv;
   logic areset, mstart, cdis, high_impedance_mode, regon, sysbat, rev, apen, pvp, bigcap, input_current_optimizer, cmpen, clen, pmsub, pin, pin_oe, vld;
   logic [3:0] amps;
   logic [3:0] amp_tab [4];
   int fail_count = 0;
   int total_checks = 0;
   int start_cnt = 0;
   int rst_cnt = 0;
   co3_option_reg dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cmd_i(b_cmd), .wr_i(b_wr),
      .wdata_i(b_wd), .rd_i(b_rd), .rdata_o(b_rdata), .rd_valid_o(b_rv), .external_mode_pin_i(ext_pin),
      .battery_only_i(batt_only), .input_above_uvlo_i(uvlo_ok), .remeasure_done_i(m_done),
      .minimum_system_voltage_i(vmin_in), .all_reg_reset_o(areset), .remeasure_start_o(mstart),
      .converter_disable_o(cdis), .high_impedance_mode_o(high_impedance_mode), .regulator_on_o(regon),
      .system_from_battery_o(sysbat), .reverse_supply_active_o(rev), .active_protection_pin_en_o(apen),
      .port_voltage_protection_o(pvp), .large_port_capacitance_comp_o(bigcap),
      .input_current_optimizer_enable_o(input_current_optimizer), .independent_comparator_enable_o(cmpen),
      .clamp_enable_o(clen), .clamp_amps_o(amps), .power_monitor_subtract_port_o(pmsub),
      .minimum_system_voltage_o(vmin_out), .battery_switch_driver_pin_o(pin),
      .battery_switch_driver_pin_oe_o(pin_oe));
   co3_host_model host_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_o(b_cmd), .wr_o(b_wr), .wdata_o(b_wd),
      .rd_o(b_rd), .rdata_i(b_rdata), .rd_valid_i(b_rv), .remeasure_start_i(mstart), .remeasure_done_o(m_done));
   // Clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Pulse counters for the self-clearing actions
   always @(posedge clk_i) begin
      if (mstart === 1'b1) start_cnt++;
      if (areset === 1'b1) rst_cnt++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic settle();
      repeat (2) @(negedge clk_i);
   endtask : settle
   task automatic wr_reg(input logic [15:0] d);
      host_u.write_reg(CO3_CMD, d);
      settle();
   endtask : wr_reg
   task automatic rd_chk(input logic [15:0] exp);
      host_u.read_reg(CO3_CMD, rv, vld);
      `CHK(vld, 1'b1);
      `CHK(rv, exp);
   endtask : rd_chk
   task automatic done_test(input string name);
      $display("test %s finished", name);
   endtask : done_test
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Watchdog well beyond the expected run of about 900 cycles
   initial begin
      repeat (6000) @(posedge clk_i);
      fail_count++;
      summarize();
   end
   // Test sequence
   initial begin
      amp_tab = '{AMPS_6, AMPS_10, AMPS_15, 4'h0};
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      ext_pin = 1'b0;
      batt_only = 1'b0;
      uvlo_ok = 1'b1;
      vmin_in = 8'h10;
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      settle();
      rd_chk(CO3_RESET);
      `CHK({pin_oe, pin, cmpen, clen, amps, input_current_optimizer, pvp, high_impedance_mode, regon}, {4'hF, AMPS_15, 4'h1});
      host_u.read_reg(8'h33, rv, vld);
      `CHK(vld, 1'b0);
      done_test("reset");
      // Every clamp code
      for (int i = 0; i < 4; i++) begin
         wr_reg(16'h0424 | 16'(i << 3));
         `CHK({clen, amps}, {1'(i != 3), amp_tab[i]});
      end
      wr_reg(16'h0970);
      `CHK({input_current_optimizer, pvp, cmpen, pin_oe}, 4'hC);
      rd_chk(16'h0970);
      done_test("fields");
      // Enable low: a write is ignored and outputs hold
      @(posedge clk_i);
      ce_i <= 1'b0;
      host_u.write_reg(CO3_CMD, 16'h0434);
      settle();
      `CHK(input_current_optimizer, 1'b1);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rd_chk(16'h0970);
      done_test("clock_enable");
      @(posedge clk_i);
      uvlo_ok <= 1'b0;
      wr_reg(16'h8436);
      `CHK({high_impedance_mode, sysbat, cdis, pin, regon}, 5'h1C);
      @(posedge clk_i);
      uvlo_ok <= 1'b1;
      wr_reg(16'h8434);
      `CHK({pin, regon}, 2'h3);
      done_test("high_impedance");
      wr_reg(16'h04B4);
      rd_chk(16'h0434);
      @(posedge clk_i);
      batt_only <= 1'b1;
      wr_reg(16'h04B4);
      rd_chk(16'h04B4);
      `CHK(pin, 1'b0);
      @(posedge clk_i);
      ext_pin <= 1'b1;
      wr_reg(16'h1434);
      wr_reg(16'h14B4);
      rd_chk(16'h1434);
      done_test("switch_force_off");
      // Reverse supply needs both the enable bit and the pin
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         ext_pin <= i[0];
         wr_reg(16'h0534 | (i[1] ? 16'h1000 : 16'h0000));
         `CHK({rev, bigcap, pmsub}, {3{1'(i == 3)}});
      end
      wr_reg(16'h1535);
      `CHK({rev, pmsub}, 2'h2);
      @(posedge clk_i);
      ext_pin <= 1'b0;
      wr_reg(16'h1515);
      @(posedge clk_i);
      ext_pin <= 1'b1;
      settle();
      `CHK({rev, apen}, 2'h1);
      @(posedge clk_i);
      ext_pin <= 1'b0;
      batt_only <= 1'b0;
      done_test("reverse_supply");
      // Remeasure stops the converter and the bit reads set until measurement is done
      wr_reg(16'h2434);
      `CHK({start_cnt[1:0], cdis}, 3'h3);
      rd_chk(16'h2434);
      repeat (60) @(negedge clk_i);
      rd_chk(16'h0434);
      `CHK(cdis, 1'b0);
      host_u.meas_delay = 1;
      wr_reg(16'h2434);
      repeat (6) @(negedge clk_i);
      rd_chk(16'h0434);
      done_test("remeasure");
      host_u.meas_delay = 200;
      wr_reg(16'h2C34);
      wr_reg(16'h4000);
      `CHK({rst_cnt[1:0], start_cnt[1:0], cdis}, 5'h0E);
      rd_chk(16'h0434);
      done_test("reset_all");
      @(posedge clk_i);
      vmin_in <= 8'h12;
      repeat (3) @(negedge clk_i);
      `CHK(vmin_out, 8'h12);
      wr_reg(16'h0634);
      @(posedge clk_i);
      vmin_in <= 8'h10;
      repeat (5) @(negedge clk_i);
      `CHK(vmin_out >= 8'h11, 1'b1);
      repeat (700) @(negedge clk_i);
      `CHK(vmin_out, 8'h10);
      done_test("soft_slew");
      summarize();
   end
endmodule : charger_option_three_register_tb_top
